// file: rtl/ivp_defines.svh
// request numbers, vector layout and i/o gap ranges of the interrupt map
// assumes inclusion by bare name from every design file
`ifndef IVP_DEFINES_SVH
`define IVP_DEFINES_SVH
`define IVP_NUM_IRQ        24
`define IVP_LEVEL_W        2
`define IVP_LEVEL_RESET    2'h3
`define IVP_VEC_TOP        16'hfffa
`define IVP_IRQ_EXT0       5'h00
`define IVP_IRQ_UART_SIO   5'h04
`define IVP_IRQ_CT_LO      5'h05
`define IVP_IRQ_CT_HI      5'h06
`define IVP_IRQ_LIN_RX     5'h07
`define IVP_IRQ_LIN_TX     5'h08
`define IVP_IRQ_PPG8_HI    5'h0c
`define IVP_IRQ_PPG8_LO    5'h0d
`define IVP_IRQ_PPG16      5'h0f
`define IVP_IRQ_ADC        5'h12
`define IVP_IRQ_TIMEBASE   5'h13
`define IVP_IRQ_WATCH      5'h14
`define IVP_IRQ_FLASH      5'h17
`define IVP_GAP_COUNT      16
`define IVP_GAP_LO_LIST    {16'h004c, 16'h005b, 16'h0071, 16'h0075, 16'h007f, 16'h0f89, \
                            16'h0f97, 16'h0fa0, 16'h0fa6, 16'h0fb0, 16'h0fc0, 16'h0fc4, \
                            16'h0fe4, 16'h0fe8, 16'h0feb, 16'h0ff0}
`define IVP_GAP_HI_LIST    {16'h004f, 16'h006b, 16'h0071, 16'h0075, 16'h007f, 16'h0f91, \
                            16'h0f9b, 16'h0fa3, 16'h0fa9, 16'h0fbb, 16'h0fc2, 16'h0fe2, \
                            16'h0fe6, 16'h0fe9, 16'h0fed, 16'h0fff}
`endif

// file: rtl/ivp_pkg.sv
// types shared by the interrupt map and its arbiter
// assumes nothing beyond the defines header
`include "ivp_defines.svh"
package ivp_pkg;
  typedef logic [4:0]                ivp_irq_t;
  typedef logic [`IVP_LEVEL_W-1:0]   ivp_level_t;
  typedef logic [`IVP_NUM_IRQ-1:0]   ivp_req_t;
  typedef logic [15:0]               ivp_addr_t;
endpackage

// file: rtl/ivp_arb_if.sv
// carrier between the map and its arbiter: requests, levels and the winner
// assumes both ends on the same clock
`timescale 1ns/1ps
`include "ivp_defines.svh"
interface ivp_arb_if;
  ivp_pkg::ivp_req_t   req;
  ivp_pkg::ivp_level_t level [`IVP_NUM_IRQ];
  logic                found;
  ivp_pkg::ivp_irq_t   num;
  ivp_pkg::ivp_level_t win_level;
  modport map (output req, output level, input found, input num, input win_level);
  modport arb (input req, input level, output found, output num, output win_level);
endinterface

// file: rtl/ivp_arbiter.sv
// combinational choice of the request to serve among those pending
// assumes requests and levels come from logic on the same clock
`timescale 1ns/1ps
`include "ivp_defines.svh"
module ivp_arbiter (
  ivp_arb_if.arb arb
);
  // level then number
  // strict compare keeps the earlier, lower-numbered request on a tie
  always_comb begin
    arb.found     = 1'b0;
    arb.num       = 5'h00;
    arb.win_level = `IVP_LEVEL_RESET;
    for (int n = 0; n < `IVP_NUM_IRQ; n++) begin
      if (arb.req[n] && (!arb.found || arb.level[n] < arb.win_level)) begin
        arb.found     = 1'b1;
        arb.num       = ivp_pkg::ivp_irq_t'(n);
        arb.win_level = arb.level[n];
      end
    end
  end
endmodule

// file: rtl/ivp_map.sv
// interrupt source map: peripheral events to numbered requests, vectors, levels
// also flags i/o accesses that fall in unimplemented gaps of the register map
// assumes source lines and level fields come from logic on clk; levels held elsewhere
//
// Overview of operation
// - compound timer lower half raises request 5, vector FFF0, level field 5.
// - compound timer upper half raises request 6, vector FFEE, level field 6.
// - pulse generator upper part raises request 12, vector FFE2, level field 12.
// - pulse generator lower part raises request 13, vector FFE0, level field 13.
// - two-bit level per request; ties go to the lowest request number.
// - reads of unimplemented i/o addresses return an undefined value.
`timescale 1ns/1ps
`include "ivp_defines.svh"
module ivp_map (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            ext_int,
  input  wire logic                  uart_sio_int,
  input  wire logic                  ct_lo_int,
  input  wire logic                  ct_hi_int,
  input  wire logic                  lin_rx_int,
  input  wire logic                  lin_tx_int,
  input  wire logic                  ppg8_hi_int,
  input  wire logic                  ppg8_lo_int,
  input  wire logic                  ppg16_int,
  input  wire logic                  adc_int,
  input  wire logic                  timebase_int,
  input  wire logic                  watch_int,
  input  wire logic                  flash_int,
  input  wire logic [47:0]           level_fields,
  input  wire logic [15:0]           io_addr,
  input  wire logic                  io_rd,
  input  wire logic                  io_wr,
  input  wire logic [7:0]            io_wdata,
  output logic                       irq_valid,
  output ivp_pkg::ivp_irq_t          irq_num,
  output ivp_pkg::ivp_level_t        irq_level,
  output ivp_pkg::ivp_addr_t         irq_vector,
  output ivp_pkg::ivp_req_t          irq_pending,
  output logic                       io_gap_hit,
  output logic [7:0]                 io_gap_rdata,
  output logic                       io_gap_wr_err
);
  // arbitration is combinational; the registers below give the one-cycle answer
  ivp_arb_if arb_if ();

  ivp_arbiter u_arb (
    .arb (arb_if.arb)
  );

  logic                  irq_valid_reg;
  ivp_pkg::ivp_irq_t     irq_num_reg;
  ivp_pkg::ivp_level_t   irq_level_reg;
  ivp_pkg::ivp_addr_t    irq_vector_reg;
  ivp_pkg::ivp_req_t     irq_pending_reg;
  logic                  io_gap_hit_reg;
  logic [7:0]            io_gap_rdata_reg;
  logic                  io_gap_wr_err_reg;
  logic [7:0]            bus_hold_reg;
  ivp_pkg::ivp_req_t     req_next;
  logic                  gap_now;
  ivp_pkg::ivp_addr_t    irq_vector_next;
  logic                  gap_rd_next;
  logic                  gap_wr_next;

  // upper vector byte address: two bytes per request counting down
  function automatic ivp_pkg::ivp_addr_t vec_of(input ivp_pkg::ivp_irq_t n);
    vec_of = `IVP_VEC_TOP - {10'h000, n, 1'b0};
  endfunction

  // gap ranges are inclusive at both ends
  function automatic logic in_gap(input ivp_pkg::ivp_addr_t a);
    logic [16*`IVP_GAP_COUNT-1:0] lo;
    logic [16*`IVP_GAP_COUNT-1:0] hi;
    lo = `IVP_GAP_LO_LIST;
    hi = `IVP_GAP_HI_LIST;
    in_gap = 1'b0;
    for (int g = 0; g < `IVP_GAP_COUNT; g++) begin
      if (a >= lo[16*g +: 16] && a <= hi[16*g +: 16]) begin
        in_gap = 1'b1;
      end
    end
  endfunction

  always_comb begin
    req_next = '0;
    // external channels n and n+4 share request n
    for (int n = 0; n < 4; n++) begin
      req_next[`IVP_IRQ_EXT0 + n] = ext_int[n] | ext_int[n+4];
    end
    req_next[`IVP_IRQ_UART_SIO] = uart_sio_int;
    req_next[`IVP_IRQ_LIN_RX]   = lin_rx_int;
    req_next[`IVP_IRQ_LIN_TX]   = lin_tx_int;
    req_next[`IVP_IRQ_CT_LO]    = ct_lo_int;
    req_next[`IVP_IRQ_CT_HI]    = ct_hi_int;
    req_next[`IVP_IRQ_PPG8_HI]  = ppg8_hi_int;
    req_next[`IVP_IRQ_PPG8_LO]  = ppg8_lo_int;
    req_next[`IVP_IRQ_PPG16]    = ppg16_int;
    req_next[`IVP_IRQ_ADC]      = adc_int;
    req_next[`IVP_IRQ_TIMEBASE] = timebase_int;
    req_next[`IVP_IRQ_WATCH]    = watch_int;
    req_next[`IVP_IRQ_FLASH]    = flash_int;
  end

  // sources are levels, not latched: a source must hold its line until served
  assign arb_if.req = req_next;

  // unused numbers pass their fields too; their sources are tied low
  // one level field per request
  always_comb begin
    for (int n = 0; n < `IVP_NUM_IRQ; n++) begin
      arb_if.level[n] = level_fields[2*n +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_pending_reg <= '0;
    end else begin
      irq_pending_reg <= req_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_valid_reg <= 1'b0;
    end else begin
      irq_valid_reg <= arb_if.found;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_num_reg <= 5'h00;
    end else begin
      irq_num_reg <= arb_if.num;
    end
  end

  // level of the winner
  // reset shows the lowest priority so nothing looks urgent out of reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_level_reg <= `IVP_LEVEL_RESET;
    end else begin
      irq_level_reg <= arb_if.win_level;
    end
  end

  // vector word from the winner's number
  assign irq_vector_next = vec_of(arb_if.num);

  // with no winner it still names request 0; read it only with irq_valid
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_vector_reg <= `IVP_VEC_TOP;
    end else begin
      irq_vector_reg <= irq_vector_next;
    end
  end

  // decoded every cycle; only a strobe makes it count
  assign gap_now = in_gap(io_addr);

  // last data written on the bus; a gap read echoes it, so software gets no promise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_hold_reg <= 8'h00;
    end else if (io_wr) begin
      bus_hold_reg <= io_wdata;
    end
  end

  assign gap_rd_next = io_rd & gap_now;
  assign gap_wr_next = io_wr & gap_now;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_gap_hit_reg <= 1'b0;
    end else begin
      io_gap_hit_reg <= gap_rd_next | gap_wr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_gap_rdata_reg <= 8'h00;
    end else begin
      io_gap_rdata_reg <= gap_rd_next ? bus_hold_reg : 8'h00;
    end
  end

  // gap writes flagged
  // the write itself lands nowhere; the flag only exposes a broken bus side
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_gap_wr_err_reg <= 1'b0;
    end else begin
      io_gap_wr_err_reg <= gap_wr_next;
    end
  end

  assign irq_valid     = irq_valid_reg;
  assign irq_num       = irq_num_reg;
  assign irq_level     = irq_level_reg;
  assign irq_vector    = irq_vector_reg;
  assign irq_pending   = irq_pending_reg;
  assign io_gap_hit    = io_gap_hit_reg;
  assign io_gap_rdata  = io_gap_rdata_reg;
  assign io_gap_wr_err = io_gap_wr_err_reg;
endmodule

// file: verif/ivp_map_monitor.sv
// checker for the interrupt map: source mapping, chosen level, vectors, gap read hit flag
// assumes bind onto ivp_map, one clock, synchronous reset
`timescale 1ns/1ps
module ivp_map_monitor (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic [7:0]          ext_int,
  input wire logic                ct_lo_int,
  input wire logic                ct_hi_int,
  input wire logic                ppg8_hi_int,
  input wire logic                ppg8_lo_int,
  input wire logic [47:0]         level_fields,
  input wire logic [15:0]         io_addr,
  input wire logic                io_rd,
  input wire logic                irq_valid,
  input wire ivp_pkg::ivp_irq_t   irq_num,
  input wire ivp_pkg::ivp_level_t irq_level,
  input wire ivp_pkg::ivp_addr_t  irq_vector,
  input wire ivp_pkg::ivp_req_t   irq_pending,
  input wire logic                io_gap_hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // levels as the map saw them, so the winner's level can be tied to its field
  logic [47:0] lvl_q;
  always_ff @(posedge clk) begin
    lvl_q <= level_fields;
  end
  ct_lo_map_a: assert property (ct_lo_int |=> irq_pending[5]) else $error("ct lo lost");
  ct_hi_map_a: assert property (ct_hi_int |=> irq_pending[6]) else $error("ct hi lost");
  pg_hi_map_a: assert property (ppg8_hi_int |=> irq_pending[12]) else $error("pg hi lost");
  pg_lo_map_a: assert property (ppg8_lo_int |=> irq_pending[13]) else $error("pg lo lost");
  vector_calc_a: assert property (irq_valid |-> irq_vector == 16'hfffa - {10'h0, irq_num, 1'b0})
    else $error("bad vector");
  win_level_a: assert property (irq_valid |-> irq_level == lvl_q[2*irq_num+:2])
    else $error("bad level");
  valid_any_a: assert property (irq_valid == |irq_pending) else $error("valid mismatch");
  unused_idle_a: assert property ((irq_pending & 24'h634e00) == 24'h0)
    else $error("unused pending");
  ext_share_a: assert property (ext_int[1] && ext_int[5] |=> irq_pending[1])
    else $error("ext share");
  gap_read_a: assert property (io_rd && io_addr inside {[16'h0fa6:16'h0fa9]} |=> io_gap_hit)
    else $error("gap read missed");
  cover property (irq_valid && irq_num == 5'h05);
  cover property (irq_pending[12] && irq_pending[13]);
  cover property (io_rd ##1 io_gap_hit);
endmodule
bind ivp_map ivp_map_monitor mon (
  .clk          (clk),
  .sys_rst      (sys_rst),
  .ext_int      (ext_int),
  .ct_lo_int    (ct_lo_int),
  .ct_hi_int    (ct_hi_int),
  .ppg8_hi_int  (ppg8_hi_int),
  .ppg8_lo_int  (ppg8_lo_int),
  .level_fields (level_fields),
  .io_addr      (io_addr),
  .io_rd        (io_rd),
  .irq_valid    (irq_valid),
  .irq_num      (irq_num),
  .irq_level    (irq_level),
  .irq_vector   (irq_vector),
  .irq_pending  (irq_pending),
  .io_gap_hit   (io_gap_hit)
);

// file: verif/ivp_src_model.sv
// peripheral side: interrupt source lines raised from a request word
// assumes the bench updates fire on clk; sources hold their level while asked
`timescale 1ns/1ps
module ivp_src_model (
  input  wire logic        clk,
  input  wire logic [19:0] fire,
  output logic      [19:0] line
);
  // a peripheral flags its event one edge after it occurs and keeps it up
  always_ff @(posedge clk) begin
    line <= fire;
  end
endmodule

// file: verif/ivp_map_tb_top.sv
// self-checking bench for the interrupt map with a peripheral source model
// assumes expected results are queued by the drivers and checked at falling edges
`timescale 1ns/1ps
module ivp_map_tb_top;
  typedef struct {int due; logic [57:0] e; logic [57:0] m;} ivp_note_s;
  logic clk = 0, sys_rst = 1, io_rd = 0, io_wr = 0, irq_valid, io_gap_hit, io_gap_wr_err;
  logic [19:0] fire = 0, line;
  logic [47:0] lvl = 0;
  logic [15:0] io_addr = 0;
  logic [7:0]  io_wdata = 0, last_wd = 0, io_gap_rdata;
  ivp_pkg::ivp_irq_t irq_num;
  ivp_pkg::ivp_level_t irq_level;
  ivp_pkg::ivp_addr_t irq_vector;
  ivp_pkg::ivp_req_t irq_pending;
  int cyc = 0, err_total = 0, comparisons = 0;
  ivp_note_s q[$], cur;
  logic [15:0] ga [8] = '{16'h0fa6, 16'h0fa9, 16'h004c, 16'h0fff, 16'h0071, 16'h0fa5,
                          16'h0faa, 16'h0fe3};
  always #4 clk = ~clk;
  ivp_src_model SRC (.clk(clk), .fire(fire), .line(line));
  ivp_map DUT (.clk(clk), .sys_rst(sys_rst), .ext_int(line[7:0]), .uart_sio_int(line[8]),
    .ct_lo_int(line[9]), .ct_hi_int(line[10]), .lin_rx_int(line[11]), .lin_tx_int(line[12]),
    .ppg8_hi_int(line[13]), .ppg8_lo_int(line[14]), .ppg16_int(line[15]), .adc_int(line[16]),
    .timebase_int(line[17]), .watch_int(line[18]), .flash_int(line[19]), .level_fields(lvl),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .irq_valid(irq_valid),
    .irq_num(irq_num), .irq_level(irq_level), .irq_vector(irq_vector), .irq_pending(irq_pending),
    .io_gap_hit(io_gap_hit), .io_gap_wr_err(io_gap_wr_err), .io_gap_rdata(io_gap_rdata));
  task automatic chk(input logic [57:0] seen, input logic [57:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (q.size() > 0) err_total++;
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // expected winner: lowest level, then lowest number
  task automatic irq_op(input logic [19:0] f, input logic [47:0] l);
    int map [12] = '{4, 5, 6, 7, 8, 12, 13, 15, 18, 19, 20, 23};
    logic [23:0] r;
    int w;
    int v;
    ivp_note_s n;
    @(posedge clk);
    fire <= f;
    lvl <= l;
    r = 24'h0;
    w = -1;
    for (int k = 0; k < 8; k++) if (f[k]) r[k%4] = 1'b1;
    for (int k = 0; k < 12; k++) if (f[k+8]) r[map[k]] = 1'b1;
    for (int k = 23; k >= 0; k--) if (r[k] && (w < 0 || l[2*k+:2] <= l[2*w+:2])) w = k;
    v = (w < 0) ? 0 : w;
    n.due = cyc + 3;
    n.m = {1'b1, {23{w >= 0}}, 24'hffffff, 10'h0};
    n.e = {w >= 0, 5'(v), l[2*v+:2], 16'hfffa - 16'(2 * v), r, 10'h0};
    q.push_back(n);
    @(posedge clk);
  endtask
  // gap flags; undefined read data seen here as the last bus write
  task automatic io_op(input logic r, input logic [15:0] a, input logic [7:0] d, input logic g);
    ivp_note_s n;
    @(posedge clk);
    io_rd <= r;
    io_wr <= !r;
    io_addr <= a;
    if (!r) io_wdata <= d;
    n.due = cyc + 2;
    n.m = {48'h0, 10'h3ff};
    n.e = {48'h0, g, g && !r, (g && r) ? last_wd : 8'h0};
    if (!r) last_wd = d;
    q.push_back(n);
  endtask
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      cur = q.pop_front();
      chk({irq_valid, irq_num, irq_level, irq_vector, irq_pending, io_gap_hit, io_gap_wr_err,
           io_gap_rdata} & cur.m, cur.e & cur.m);
    end
  end
  // bounds a hang; the full sequence needs about 150 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h063d5204));
    // reset values, checked at the falling edge just after reset is released
    q.push_back('{2, {1'b0, 5'h00, 2'h3, 16'hfffa, 24'h0, 10'h0}, {58{1'b1}}});
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 20; k++) irq_op(20'h1 << k, 48'hffffffffffff);
    // equal levels then a lower level
    irq_op(20'h06600, 48'haaaaaaaaaaaa);
    irq_op(20'h06600, 48'haaaaaaaaaaaa & ~(48'h3 << 26));
    irq_op(20'h00012, 48'h555555555555);
    irq_op(20'h0, 48'h0);
    for (int k = 0; k < 40; k++) irq_op(20'($urandom), {16'($urandom), $urandom});
    for (int k = 0; k < 8; k++) begin
      io_op(1'b0, (k < 5) ? 16'h0fa4 : ga[k], 8'($urandom), 1'b0);
      io_op(1'b1, ga[k], 8'h0, k < 5);
    end
    @(posedge clk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
